// >>> rtl/ep_fifo_ctrl.sv
// Device end: transmit/receive endpoint FIFOs, command and status registers
module ep_fifo_ctrl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic tx_level_warning_o,
    output logic rx_level_warning_o,
    ep_link_if.device link
);
    logic [7:0] tx_mem [ep_fifo_pkg::FIFO_DEPTH];
    logic [7:0] rx_mem [ep_fifo_pkg::FIFO_DEPTH];
    logic [ep_fifo_pkg::PTR_W-1:0] tx_read_pointer, tx_wr_ptr, tx_saved_ptr;
    logic [ep_fifo_pkg::PTR_W-1:0] rx_rd_ptr, rx_wr_ptr;
    logic [ep_fifo_pkg::CNT_W-1:0] tx_cnt, rx_cnt;
    logic [7:0] tx_cmd, rx_cmd;
    logic [7:0] stat_a, stat_b;
    logic stat_b_valid, setup_held, rx_flush_pend, rx_setup_pkt, rx_drop, rx_was_empty;
    logic tx_wr, rx_rd, tx_pop, rx_push, tx_flush_now, rx_flush_now, refill_now;
    logic setup_tok, out_tok, in_tok, setup_ok, out_ok, in_ok, frame_ok;
    logic [7:0] next_stat;
    logic [ep_fifo_pkg::CNT_W-1:0] rx_free;

    // Token qualification
    assign setup_tok = link.token_valid && link.token == ep_fifo_pkg::TOK_SETUP;
    assign out_tok = link.token_valid && link.token == ep_fifo_pkg::TOK_OUT;
    assign in_tok = link.token_valid && link.token == ep_fifo_pkg::TOK_IN;
    assign frame_ok = tx_cmd[ep_fifo_pkg::TXC_ISO_UNLOCK]
        || link.frame_bit0 == tx_cmd[ep_fifo_pkg::TXC_TOGGLE];
    assign link.in_ready = tx_cmd[ep_fifo_pkg::TXC_EN] && !link.stall
        && (!link.iso || frame_ok);
    assign in_ok = in_tok && link.in_ready;
    // A pending flush or a parked second status cannot take another setup
    assign setup_ok = setup_tok && !rx_cmd[ep_fifo_pkg::RXC_SETUP_IGN]
        && !stat_b_valid && !rx_flush_pend;
    assign out_ok = out_tok && rx_cmd[ep_fifo_pkg::RXC_EN] && !link.stall;

    // Handshake answer to each token
    always_comb begin
        link.handshake = ep_fifo_pkg::HS_NONE;
        link.handshake_valid = 1'b0;
        if (setup_tok && !rx_cmd[ep_fifo_pkg::RXC_SETUP_IGN]) begin
            link.handshake_valid = setup_held || setup_ok;
            link.handshake = ep_fifo_pkg::HS_ACK;
        end else if ((out_tok || in_tok) && link.stall && !link.iso) begin
            link.handshake_valid = 1'b1;
            link.handshake = ep_fifo_pkg::HS_STALL;
        end else if (out_tok && !out_ok && !link.iso) begin
            link.handshake_valid = 1'b1;
            link.handshake = ep_fifo_pkg::HS_NAK;
        end else if (link.rx_end && link.rx_good && !rx_drop && !link.iso) begin
            link.handshake_valid = 1'b1;
            link.handshake = ep_fifo_pkg::HS_ACK;
        end
    end

    // Transmit path: engine adds PID and CRC16 around these bytes
    assign tx_wr = reg_wr_i && reg_addr_i == ep_fifo_pkg::REG_TX_DATA;
    assign tx_pop = link.tx_byte_req && tx_cnt != '0;
    assign tx_flush_now = tx_cmd[ep_fifo_pkg::TXC_FLUSH] && !link.tx_busy;
    assign refill_now = tx_cmd[ep_fifo_pkg::TXC_REFILL] && !link.tx_busy;

    always_ff @(posedge clk_i) begin
        if (tx_wr) begin
            tx_mem[tx_wr_ptr] <= reg_wdata_i;
        end
        if (rx_push) begin
            rx_mem[rx_wr_ptr] <= link.rx_byte;
        end
    end

    // Transmit byte stream to the engine
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            link.tx_byte <= '0;
            link.tx_byte_valid <= 1'b0;
        end else begin
            link.tx_byte_valid <= tx_pop;
            if (tx_pop) begin
                link.tx_byte <= tx_mem[tx_read_pointer];
            end
        end
    end

    // Transmit pointers and count
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || tx_flush_now) begin
            tx_read_pointer <= '0;
            tx_wr_ptr <= '0;
            tx_cnt <= '0;
        end else if (refill_now) begin
            tx_read_pointer <= tx_saved_ptr;
            tx_cnt <= ep_fifo_pkg::CNT_W'(tx_wr_ptr - tx_saved_ptr)
                + (tx_cnt == ep_fifo_pkg::FIFO_FULL_CNT ? ep_fifo_pkg::FIFO_FULL_CNT : '0);
        end else begin
            if (tx_wr && tx_cnt != ep_fifo_pkg::FIFO_FULL_CNT) begin
                tx_wr_ptr <= tx_wr_ptr + 1'b1;
            end
            if (tx_pop) begin
                tx_read_pointer <= tx_read_pointer + 1'b1;
            end
            tx_cnt <= tx_cnt + ((tx_wr && tx_cnt != ep_fifo_pkg::FIFO_FULL_CNT) ? 7'h01 : 7'h00)
                - (tx_pop ? 7'h01 : 7'h00);
        end
    end

    // Save point for retransmission, taken when software marks the last byte
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_saved_ptr <= '0;
        end else if (reg_wr_i && reg_addr_i == ep_fifo_pkg::REG_TX_CMD
                && reg_wdata_i[ep_fifo_pkg::TXC_LAST]) begin
            tx_saved_ptr <= tx_read_pointer;
        end
    end

    // Transmit command register; hardware clears arm, last, flush, refill
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_cmd <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == ep_fifo_pkg::REG_TX_CMD) begin
                tx_cmd <= reg_wdata_i;
            end
            if (link.tx_end || (in_tok && link.stall && !link.iso)) begin
                tx_cmd[ep_fifo_pkg::TXC_EN] <= 1'b0;
                tx_cmd[ep_fifo_pkg::TXC_LAST] <= 1'b0;
            end
            if (tx_flush_now) begin
                tx_cmd[ep_fifo_pkg::TXC_FLUSH] <= 1'b0;
            end
            if (refill_now) begin
                tx_cmd[ep_fifo_pkg::TXC_REFILL] <= 1'b0;
            end
        end
    end

    // Receive path: engine strips PID and CRC16 before bytes arrive here
    assign rx_rd = reg_rd_i && reg_addr_i == ep_fifo_pkg::REG_RX_DATA;
    assign rx_push = link.rx_byte_valid && !rx_drop && rx_cnt != ep_fifo_pkg::FIFO_FULL_CNT;
    assign rx_flush_now = rx_flush_pend && !link.rx_busy;
    assign rx_free = ep_fifo_pkg::FIFO_FULL_CNT - rx_cnt;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || rx_flush_now) begin
            rx_rd_ptr <= '0;
            rx_wr_ptr <= '0;
            rx_cnt <= '0;
        end else begin
            if (rx_push) begin
                rx_wr_ptr <= rx_wr_ptr + 1'b1;
            end
            if (rx_rd && rx_cnt != '0) begin
                rx_rd_ptr <= rx_rd_ptr + 1'b1;
            end
            rx_cnt <= rx_cnt + (rx_push ? 7'h01 : 7'h00)
                - ((rx_rd && rx_cnt != '0) ? 7'h01 : 7'h00);
        end
    end

    // Packet context: accept, or drop a repeated setup while still acking it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_setup_pkt <= 1'b0;
            rx_drop <= 1'b1;
            setup_held <= 1'b0;
            rx_was_empty <= 1'b0;
        end else begin
            if (setup_tok && !rx_cmd[ep_fifo_pkg::RXC_SETUP_IGN]) begin
                rx_setup_pkt <= 1'b1;
                rx_drop <= setup_held || !setup_ok;
                rx_was_empty <= rx_cnt == '0; // Count before setup bytes land
            end else if (out_tok) begin
                rx_setup_pkt <= 1'b0;
                rx_drop <= !out_ok;
            end else if (link.token_valid) begin
                rx_drop <= 1'b1;
            end
            if (link.token_valid && link.token != ep_fifo_pkg::TOK_SETUP) begin
                setup_held <= 1'b0;
            end else if (link.rx_end && link.rx_good && rx_setup_pkt && !rx_drop) begin
                setup_held <= 1'b1;
            end
        end
    end

    // Status of a finished packet
    always_comb begin
        next_stat = '0;
        next_stat[ep_fifo_pkg::RXS_ERR] = link.rx_media_err;
        next_stat[ep_fifo_pkg::RXS_SETUP] = rx_setup_pkt;
        next_stat[ep_fifo_pkg::RXS_TOGGLE] = link.rx_good
            && (link.iso ? link.frame_bit0 : link.rx_pid1);
        next_stat[ep_fifo_pkg::RXS_LAST] = link.iso || link.rx_good;
    end

    // Two status copies; a read retires the older, a new packet never loses
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stat_a <= '0;
            stat_b <= '0;
            stat_b_valid <= 1'b0;
        end else begin
            if (reg_rd_i && reg_addr_i == ep_fifo_pkg::REG_RX_STATUS) begin
                stat_a <= stat_b_valid ? stat_b : 8'h00;
                stat_b_valid <= 1'b0;
                if (link.rx_end && !rx_drop) begin
                    if (stat_b_valid) begin
                        stat_b <= next_stat;
                        stat_b_valid <= 1'b1;
                    end else begin
                        stat_a <= next_stat;
                    end
                end
            end else if (link.rx_end && !rx_drop) begin
                if (stat_a[ep_fifo_pkg::RXS_LAST] && rx_was_empty && rx_setup_pkt) begin
                    stat_b <= next_stat;
                    stat_b_valid <= 1'b1;
                end else begin
                    stat_a <= next_stat | (stat_a & 8'he0);
                end
            end
        end
    end

    // Receive command register; hardware clears arm and flush
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_cmd <= '0;
            rx_flush_pend <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == ep_fifo_pkg::REG_RX_CMD) begin
                rx_cmd <= reg_wdata_i & 8'h6d;
                rx_flush_pend <= rx_flush_pend || reg_wdata_i[ep_fifo_pkg::RXC_FLUSH];
            end
            if ((link.rx_end && !rx_drop && !rx_setup_pkt) || (out_tok && link.stall)) begin
                rx_cmd[ep_fifo_pkg::RXC_EN] <= 1'b0;
            end
            if (rx_flush_now) begin
                rx_flush_pend <= 1'b0;
                rx_cmd[ep_fifo_pkg::RXC_FLUSH] <= 1'b0;
            end
        end
    end

    // Warnings: transmit gated by arm so pre-filling stays quiet
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_level_warning_o <= 1'b0;
            rx_level_warning_o <= 1'b0;
        end else begin
            tx_level_warning_o <= tx_cmd[ep_fifo_pkg::TXC_WL_LO+:2] != 2'h0
                && tx_cmd[ep_fifo_pkg::TXC_EN]
                && tx_cnt <= ep_fifo_pkg::warn_limit(tx_cmd[ep_fifo_pkg::TXC_WL_LO+:2]);
            rx_level_warning_o <= rx_cmd[ep_fifo_pkg::RXC_WL_LO+:2] != 2'h0
                && rx_free <= ep_fifo_pkg::warn_limit(rx_cmd[ep_fifo_pkg::RXC_WL_LO+:2]);
        end
    end

    // Read data register; status count saturates
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ep_fifo_pkg::REG_TX_CMD: reg_rdata_o <= tx_cmd;
                ep_fifo_pkg::REG_RX_CMD: reg_rdata_o <= rx_cmd;
                ep_fifo_pkg::REG_RX_DATA: reg_rdata_o <= rx_mem[rx_rd_ptr];
                ep_fifo_pkg::REG_RX_STATUS: reg_rdata_o <= {stat_a[7:4],
                    rx_cnt > 7'(ep_fifo_pkg::RX_COUNT_MAX) ? ep_fifo_pkg::RX_COUNT_MAX
                    : rx_cnt[3:0]};
                default: reg_rdata_o <= '0;
            endcase
        end
    end
endmodule

// >>> rtl/ep_fifo_pkg.sv
// Shared constants and types for the endpoint FIFO control ends
package ep_fifo_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 7'h40;
    localparam logic [3:0] RX_COUNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] WARN_4 = 7'h04;
    localparam logic [CNT_W-1:0] WARN_8 = 7'h08;
    localparam logic [CNT_W-1:0] WARN_16 = 7'h10;
    // Register selects on the CPU port (one endpoint pair)
    localparam logic [2:0] REG_TX_DATA = 3'h1;
    localparam logic [2:0] REG_TX_CMD = 3'h3;
    localparam logic [2:0] REG_RX_DATA = 3'h5;
    localparam logic [2:0] REG_RX_STATUS = 3'h6;
    localparam logic [2:0] REG_RX_CMD = 3'h7;
    // Transmit command bits
    localparam int TXC_EN = 0;
    localparam int TXC_LAST = 1;
    localparam int TXC_TOGGLE = 2;
    localparam int TXC_FLUSH = 3;
    localparam int TXC_REFILL = 4;
    localparam int TXC_WL_LO = 5;
    localparam int TXC_ISO_UNLOCK = 7;
    // Receive command bits
    localparam int RXC_EN = 0;
    localparam int RXC_SETUP_IGN = 2;
    localparam int RXC_FLUSH = 3;
    localparam int RXC_WL_LO = 5;
    // Receive status bits
    localparam int RXS_LAST = 4;
    localparam int RXS_TOGGLE = 5;
    localparam int RXS_SETUP = 6;
    localparam int RXS_ERR = 7;
    // Host link token kinds
    typedef enum logic [1:0] {
        TOK_NONE = 2'h0,
        TOK_IN = 2'h1,
        TOK_OUT = 2'h2,
        TOK_SETUP = 2'h3
    } token_type;
    // Handshake answers
    typedef enum logic [1:0] {
        HS_NONE = 2'h0,
        HS_ACK = 2'h1,
        HS_NAK = 2'h2,
        HS_STALL = 2'h3
    } handshake_type;
    function automatic logic [CNT_W-1:0] warn_limit(input logic [1:0] sel);
        case (sel)
            2'h1: warn_limit = WARN_4;
            2'h2: warn_limit = WARN_8;
            2'h3: warn_limit = WARN_16;
            default: warn_limit = '0;
        endcase
    endfunction
endpackage

// >>> rtl/ep_link_if.sv
// Link between the endpoint FIFO device end and the host-side engine end
interface ep_link_if;
    ep_fifo_pkg::token_type token;
    logic token_valid;
    logic iso;
    logic stall;
    logic frame_bit0;
    logic in_ready;
    logic tx_byte_req;
    logic [7:0] tx_byte;
    logic tx_byte_valid;
    logic tx_busy;
    logic tx_end;
    logic tx_acked;
    logic [7:0] rx_byte;
    logic rx_byte_valid;
    logic rx_busy;
    logic rx_end;
    logic rx_good;
    logic rx_pid1;
    logic rx_media_err;
    ep_fifo_pkg::handshake_type handshake;
    logic handshake_valid;
    modport device (
        input token, token_valid, iso, stall, frame_bit0, tx_byte_req, tx_busy, tx_end,
        tx_acked, rx_byte, rx_byte_valid, rx_busy, rx_end, rx_good, rx_pid1, rx_media_err,
        output in_ready, tx_byte, tx_byte_valid, handshake, handshake_valid
    );
    modport engine (
        output token, token_valid, iso, stall, frame_bit0, tx_byte_req, tx_busy, tx_end,
        tx_acked, rx_byte, rx_byte_valid, rx_busy, rx_end, rx_good, rx_pid1, rx_media_err,
        input in_ready, tx_byte, tx_byte_valid, handshake, handshake_valid
    );
endinterface

// >>> rtl/ep_link_engine.sv
// Host-facing engine end: drives tokens and packet bytes onto the endpoint link
module ep_link_engine (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire ep_fifo_pkg::token_type cmd_token_i,
    input wire logic cmd_iso_i,
    input wire logic cmd_stall_i,
    input wire logic cmd_frame_bit0_i,
    input wire logic [7:0] cmd_len_i,
    input wire logic cmd_pid1_i,
    input wire logic cmd_media_err_i,
    input wire logic cmd_host_ack_i,
    input wire logic [7:0] out_byte_i,
    output logic cmd_ready_o,
    output logic out_byte_req_o,
    output logic [7:0] in_byte_o,
    output logic in_byte_valid_o,
    output logic in_done_o,
    output ep_fifo_pkg::handshake_type handshake_o,
    output logic handshake_valid_o,
    ep_link_if.engine link
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_TOKEN = 4'h2,
        ST_SEND = 4'h4,
        ST_RECV = 4'h8
    } state_type;
    state_type state;
    logic [7:0] left;
    logic iso_q, stall_q, fb0_q, pid1_q, err_q, ack_q;
    ep_fifo_pkg::token_type tok_q;

    assign cmd_ready_o = state == ST_IDLE;
    assign out_byte_req_o = state == ST_RECV && left != 8'h00;
    assign link.token = state == ST_TOKEN ? tok_q : ep_fifo_pkg::TOK_NONE;
    assign link.token_valid = state == ST_TOKEN;
    assign link.iso = iso_q;
    assign link.stall = stall_q;
    assign link.frame_bit0 = fb0_q;
    // Engine pulls one payload byte per cycle; it frames PID and CRC16 itself
    assign link.tx_byte_req = state == ST_SEND && left != 8'h00;
    assign link.tx_busy = state == ST_SEND;
    assign link.tx_end = state == ST_SEND && left == 8'h00;
    assign link.tx_acked = link.tx_end && ack_q;
    // Payload only enters the device; PID and CRC16 stripped here
    assign link.rx_byte = out_byte_i;
    assign link.rx_byte_valid = out_byte_req_o;
    assign link.rx_busy = state == ST_RECV;
    assign link.rx_end = state == ST_RECV && left == 8'h00;
    assign link.rx_good = link.rx_end && !err_q;
    assign link.rx_pid1 = pid1_q;
    assign link.rx_media_err = link.rx_end && err_q;
    assign handshake_o = link.handshake;
    assign handshake_valid_o = link.handshake_valid;

    // Returned payload to the user side
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            in_byte_o <= '0;
            in_byte_valid_o <= 1'b0;
            in_done_o <= 1'b0;
        end else begin
            in_byte_valid_o <= link.tx_byte_valid;
            in_done_o <= link.tx_end;
            if (link.tx_byte_valid) begin
                in_byte_o <= link.tx_byte;
            end
        end
    end

    // Transaction sequencing
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            left <= '0;
            tok_q <= ep_fifo_pkg::TOK_NONE;
            {iso_q, stall_q, fb0_q, pid1_q, err_q, ack_q} <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_valid_i) begin
                        state <= ST_TOKEN;
                        tok_q <= cmd_token_i;
                        left <= cmd_len_i;
                        {iso_q, stall_q, fb0_q} <= {cmd_iso_i, cmd_stall_i, cmd_frame_bit0_i};
                        {pid1_q, err_q, ack_q} <= {cmd_pid1_i, cmd_media_err_i, cmd_host_ack_i};
                    end
                end
                ST_TOKEN: begin
                    if (tok_q == ep_fifo_pkg::TOK_IN) begin
                        state <= link.in_ready ? ST_SEND : ST_IDLE;
                    end else if (stall_q || link.handshake_valid
                            && link.handshake != ep_fifo_pkg::HS_ACK) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_RECV;
                    end
                end
                ST_SEND, ST_RECV: begin
                    if (left == 8'h00) begin
                        state <= ST_IDLE;
                    end else begin
                        left <= left - 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// >>> testbench/ep_link_sva.sv
// Protocol checker for the link between the two endpoint FIFO ends
module ep_link_sva (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire ep_fifo_pkg::token_type token,
    input wire logic token_valid,
    input wire logic iso,
    input wire logic tx_byte_req,
    input wire logic tx_byte_valid,
    input wire logic tx_end,
    input wire logic rx_end,
    input wire logic rx_good,
    input wire logic rx_media_err,
    input wire ep_fifo_pkg::handshake_type handshake,
    input wire logic handshake_valid
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Transmit bytes come one cycle after each request and never otherwise
    a_tx_byte_follows: assert property (tx_byte_req |=> tx_byte_valid)
        else $error("tx byte missing after request");
    a_tx_byte_cause: assert property (tx_byte_valid |-> $past(tx_byte_req))
        else $error("tx byte without request");
    a_tx_end_quiet: assert property (tx_end |=> !tx_byte_valid [*2])
        else $error("tx byte after packet end");
    // A setup is either acknowledged or left silent
    a_setup_ack_only: assert property (token_valid && token == ep_fifo_pkg::TOK_SETUP
        && handshake_valid |-> handshake == ep_fifo_pkg::HS_ACK)
        else $error("setup answered other than ack");
    a_ack_needs_good: assert property (handshake_valid && rx_end
        && handshake == ep_fifo_pkg::HS_ACK |-> rx_good && !rx_media_err)
        else $error("ack after bad packet");
    // Isochronous traffic carries no handshake
    a_iso_silent: assert property (handshake_valid |-> !iso)
        else $error("handshake on iso transfer");
    a_hs_moment: assert property (handshake_valid |-> token_valid || rx_end)
        else $error("handshake outside token or end");
    a_rx_end_pulse: assert property (rx_end |=> !rx_end)
        else $error("rx end longer than one cycle");
    c_setup_ack: cover property (token_valid && handshake_valid);
    c_tx_end: cover property (tx_end);
    c_rx_ack: cover property (rx_end && handshake_valid);
endmodule

// >>> testbench/usb_endpoint_fifo_control_tb.sv
// Self-checking bench joining device end and engine end
`define CHK(n, e, g) check(n, 8'(e), 8'(g))
module usb_endpoint_fifo_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cmd_valid_i = 0;
    logic cmd_iso_i = 0, cmd_fb_i = 0, cmd_pid1_i = 0, cmd_err_i = 0;
    logic [2:0] reg_addr_i = 0;
    logic [7:0] reg_wdata_i = 0, cmd_len_i = 0, out_byte_i = 0, reg_rdata_o, in_byte_o, v;
    logic cmd_ready_o, out_byte_req_o, in_byte_valid_o, hs_valid, tx_warn, rx_warn;
    ep_fifo_pkg::token_type cmd_token_i = ep_fifo_pkg::TOK_NONE;
    ep_fifo_pkg::handshake_type hs, last_hs;
    logic [7:0] sent_q[$], got_q[$], exp_q[$];
    int failures = 0, samples_checked = 0, cycles = 0, n, p;
    ep_link_if link_bus ();
    ep_fifo_ctrl i_ep_fifo_ctrl (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .tx_level_warning_o(tx_warn),
        .rx_level_warning_o(rx_warn), .link(link_bus));
    ep_link_engine i_ep_link_engine (.clk_i, .sys_rst_i, .cmd_valid_i, .cmd_token_i,
        .cmd_iso_i, .cmd_stall_i(1'b0), .cmd_frame_bit0_i(cmd_fb_i), .cmd_len_i, .cmd_pid1_i,
        .cmd_media_err_i(cmd_err_i), .cmd_host_ack_i(1'b1), .out_byte_i, .cmd_ready_o,
        .out_byte_req_o, .in_byte_o, .in_byte_valid_o, .in_done_o(), .handshake_o(hs),
        .handshake_valid_o(hs_valid), .link(link_bus));
    ep_link_sva i_ep_link_sva (.clk_i, .sys_rst_i, .token(link_bus.token),
        .token_valid(link_bus.token_valid), .iso(link_bus.iso),
        .tx_byte_req(link_bus.tx_byte_req), .tx_byte_valid(link_bus.tx_byte_valid),
        .tx_end(link_bus.tx_end), .rx_end(link_bus.rx_end), .rx_good(link_bus.rx_good),
        .rx_media_err(link_bus.rx_media_err), .handshake(link_bus.handshake),
        .handshake_valid(link_bus.handshake_valid));
    always #5 clk_i = ~clk_i;
    // Fresh random payload every cycle; the engine takes it only on request
    always @(negedge clk_i) out_byte_i <= 8'($urandom);
    // Record traffic at both user sides; a hang ends the run as a failure
    always @(posedge clk_i) begin
        if (out_byte_req_o) sent_q.push_back(out_byte_i);
        if (in_byte_valid_o) got_q.push_back(in_byte_o);
        if (hs_valid) last_hs = hs;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Warning expectation: level 0 disables, else 4, 8 or 16 bytes
    function automatic logic warn_exp(input int sel, input int cnt);
        return sel != 0 && cnt <= (2 << sel);
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(negedge clk_i);
        reg_wr_i = 0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1;
        @(negedge clk_i);
        reg_rd_i = 0;
        v = reg_rdata_o;
    endtask
    // One host transfer; wait bounded until the engine is idle again
    task automatic send(input ep_fifo_pkg::token_type t, input int len, input logic iso,
        input logic fb, input logic pid, input logic err);
        int k;
        k = 0;
        @(negedge clk_i);
        cmd_valid_i = 1;
        cmd_token_i = t;
        cmd_len_i = 8'(len);
        {cmd_iso_i, cmd_fb_i, cmd_pid1_i, cmd_err_i} = {iso, fb, pid, err};
        @(negedge clk_i);
        cmd_valid_i = 0;
        while (!cmd_ready_o && k < 200) begin
            @(negedge clk_i);
            k++;
        end
        @(negedge clk_i); // Last IN byte is registered past idle
    endtask
    task automatic complete_run;
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        n = $urandom(32'h34740738);
        repeat (16) @(negedge clk_i);
        sys_rst_i = 0;
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("status reset", 0, v);
        // Near-full OUT packet: count saturates, warning on free space
        n = 48 + $urandom_range(12);
        p = $urandom_range(1);
        wr(ep_fifo_pkg::REG_RX_CMD, 8'h01);
        send(ep_fifo_pkg::TOK_OUT, n, 0, 0, p[0], 0);
        rd(ep_fifo_pkg::REG_RX_CMD);
        `CHK("rx arm", 0, v);
        for (int i = 0; i < 4; i++) begin
            wr(ep_fifo_pkg::REG_RX_CMD, 8'(i << 5));
            repeat (2) @(negedge clk_i);
            `CHK("rx warn", warn_exp(i, 64 - n), rx_warn);
        end
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("status out", {2'b00, p[0], 5'h1f}, v);
        for (int i = 0; i < n; i++) begin
            rd(ep_fifo_pkg::REG_RX_DATA);
            `CHK("rx data", sent_q[i], v);
        end
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("status cleared", 0, v);
        // Back-to-back setups while disarmed: second is acked and dropped
        sent_q.delete();
        send(ep_fifo_pkg::TOK_SETUP, 8, 0, 0, 0, 0);
        last_hs = ep_fifo_pkg::HS_NONE;
        send(ep_fifo_pkg::TOK_SETUP, 8, 0, 0, 0, 0);
        `CHK("repeat ack", ep_fifo_pkg::HS_ACK, last_hs);
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("status setup", 8'h58, v);
        for (int i = 0; i < 8; i++) begin
            rd(ep_fifo_pkg::REG_RX_DATA);
            `CHK("setup data", sent_q[i], v);
        end
        // Ignored setup leaves no answer and no status
        wr(ep_fifo_pkg::REG_RX_CMD, 8'h04);
        last_hs = ep_fifo_pkg::HS_NONE;
        send(ep_fifo_pkg::TOK_SETUP, 4, 0, 0, 0, 0);
        `CHK("ignored hs", ep_fifo_pkg::HS_NONE, last_hs);
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("ignored status", 0, v);
        // Corrupt packet flags an error; a flush then empties the FIFO
        wr(ep_fifo_pkg::REG_RX_CMD, 8'h01);
        send(ep_fifo_pkg::TOK_OUT, 3, 0, 0, 0, 1);
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("media err", 8'h80, v & 8'hf0);
        wr(ep_fifo_pkg::REG_RX_CMD, 8'h08);
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("flushed", 0, v);
        // Zero-length OUT then setup: two status copies read in order
        wr(ep_fifo_pkg::REG_RX_CMD, 8'h01);
        send(ep_fifo_pkg::TOK_OUT, 0, 0, 0, 1, 0);
        send(ep_fifo_pkg::TOK_SETUP, 2, 0, 0, 0, 0);
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("first copy", 8'h32, v);
        rd(ep_fifo_pkg::REG_RX_STATUS);
        `CHK("second copy", 8'h52, v);
        // Transmit: warning held off until armed, then each level at 4 bytes
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(8'($urandom));
            wr(ep_fifo_pkg::REG_TX_DATA, exp_q[i]);
        end
        wr(ep_fifo_pkg::REG_TX_CMD, 8'h22);
        repeat (2) @(negedge clk_i);
        `CHK("tx warn unarmed", 0, tx_warn);
        for (int i = 0; i < 4; i++) begin
            wr(ep_fifo_pkg::REG_TX_CMD, 8'(i << 5) | 8'h03);
            repeat (2) @(negedge clk_i);
            `CHK("tx warn", warn_exp(i, 4), tx_warn);
        end
        // Send, refill, then iso frame lock blocks a mismatch and passes a match
        for (int r = 0; r < 3; r++) begin
            got_q.delete();
            send(ep_fifo_pkg::TOK_IN, 4, r != 0, r == 2, 0, 0);
            `CHK("in count", r == 1 ? 0 : 4, got_q.size());
            for (int i = 0; i < got_q.size(); i++) `CHK("in byte", exp_q[i], got_q[i]);
            if (r == 0) wr(ep_fifo_pkg::REG_TX_CMD, 8'h15); // Refill with toggle 1
        end
        complete_run();
    end
endmodule
